// File: design/mcc_host.v
// Modbus RTU master that configures a serial-to-CAN converter and reads its
// received CAN messages. Software orders it over Avalon-MM.
// Assumes a byte framer outside that handles bit timing and frame silence.
// Overview of operation
// - Serial settings: 0x0100, five words, command 3
// - Baud code 2..12 maps 300..230400 bps
// - Data bits code 0..3 means 5..8
// - Stop code 0 one, 1 two
// - Parity code 0 none, 1 odd, 2 even
// - Standard CAN rate: two words, command 4
// - CAN codes 0..8 select 10..1000 kbps
// - User CAN rate: three words, command 5
// - User rate in bps, high word first
// - Read with function 4, address 0, 9n
`timescale 1ns/10ps
`default_nettype none
`include "mcc_map.vh"
module mcc_host #(
  parameter RESP_CYC   = `MCC_RESP_TIMEOUT_MS * `MCC_CLK_MHZ * 1000,
  parameter REBOOT_CYC = `MCC_REBOOT_MS * `MCC_CLK_MHZ * 1000
) (
  input  wire        clk_sys,
  input  wire        arst_n,
  input  wire [2:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  output reg  [7:0]  tx_data,
  output reg         tx_valid,
  output reg         tx_last,
  input  wire        tx_ready,
  input  wire [7:0]  rx_data,
  input  wire        rx_valid,
  output wire        rx_ready
);
  localparam ST_IDLE   = 2'h0;
  localparam ST_SEND   = 2'h1;
  localparam ST_WAIT   = 2'h2;
  localparam ST_REBOOT = 2'h3;

  function [15:0] mcc_crc;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] x;
    begin
      x = c ^ {8'h00, d};
      for (i = 0; i < 8; i = i + 1) begin
        x = x[0] ? ((x >> 1) ^ `MCC_CRC_POLY) : (x >> 1);
      end
      mcc_crc = x;
    end
  endfunction

  reg  [1:0]  state;
  reg  [2:0]  kind;
  reg  [7:0]  node;
  reg  [9:0]  sercfg;
  reg  [3:0]  canstd;
  reg  [31:0] canusr;
  reg  [4:0]  rdcnt;
  reg         busy;
  reg         done;
  reg  [2:0]  err;
  reg  [4:0]  tx_idx;
  reg  [15:0] tx_crc;
  reg  [7:0]  rx_idx;
  reg  [7:0]  rx_len;
  reg  [15:0] rx_crc;
  reg  [7:0]  rx_hi;
  reg         rx_bad;
  reg         rx_exc;
  reg  [31:0] timer;
  reg         pop_ok;
  reg  [7:0]  body_byte;
  reg  [15:0] sel_word;
  reg  [15:0] wcount;
  reg         arg_ok;

  wire [3:0]  ser_baud  = sercfg[`MCC_SER_BAUD_LSB +: 4];
  wire [1:0]  ser_dbits = sercfg[`MCC_SER_DBITS_LSB +: 2];
  wire        ser_stop  = sercfg[`MCC_SER_STOP_BIT];
  wire [1:0]  ser_par   = sercfg[`MCC_SER_PAR_LSB +: 2];
  wire        is_read   = (kind == `MCC_KIND_READ);
  wire [15:0] rd_regs   = rdcnt * `MCC_REGS_PER_MSG;
  wire [7:0]  rd_bytes  = {rd_regs[6:0], 1'b0};
  wire [4:0]  body_len  = is_read ? 5'h06 : (5'h07 + {wcount[3:0], 1'b0});
  wire [4:0]  cmd_kind  = {2'h0, avs_writedata[2:0]};
  wire [3:0]  word_k    = (tx_idx[3:0] - 4'h7) >> 1;
  wire [15:0] cfg_addr  = `MCC_CFG_ADDR;
  wire [15:0] msg_addr  = `MCC_MSG_ADDR;
  wire        acc       = (avs_read || avs_write) && !avs_waitrequest;
  wire        rx_take   = rx_valid && rx_ready;
  wire [15:0] rx_crc_nx = mcc_crc(rx_crc, rx_data);
  wire        in_data_z = !is_read || rx_exc || rx_idx < 8'h03 || rx_idx >= rx_len - 8'h02;
  wire        buf_push  = (state == ST_WAIT) && rx_take && !in_data_z && !rx_idx[0];
  wire        buf_valid;
  wire [15:0] buf_data;
  wire        buf_pop   = acc && avs_read && avs_address == `MCC_REG_RXWORD && pop_ok;

  mcc_buf2 #(
    .WIDTH (16)
  ) u_buf (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (buf_push),
    .in_data   ({rx_hi, rx_data}),
    .in_ready  (rx_ready),
    .out_valid (buf_valid),
    .out_data  (buf_data),
    .out_ready (buf_pop)
  );

  // Word count for the command in hand
  always @* begin
    case (kind)
      `MCC_KIND_SERIAL: wcount = `MCC_WC_SERIAL;
      `MCC_KIND_CANSTD: wcount = `MCC_WC_CANSTD;
      `MCC_KIND_CANUSR: wcount = `MCC_WC_CANUSR;
      default:          wcount = rd_regs;
    endcase
  end

  // Argument check on the command about to be written
  always @* begin
    case (avs_writedata[2:0])
      `MCC_KIND_SERIAL: arg_ok = ser_baud >= `MCC_BAUD_MIN && ser_baud <= `MCC_BAUD_MAX
                              && ser_dbits <= `MCC_DBITS_MAX
                              && ser_par <= `MCC_PARITY_MAX;
      `MCC_KIND_CANSTD: arg_ok = canstd <= `MCC_CAN_MAX || canstd == `MCC_CAN_USER;
      `MCC_KIND_CANUSR: arg_ok = 1'b1;
      `MCC_KIND_READ:   arg_ok = rdcnt != 5'h00 && rdcnt <= `MCC_MAX_MSGS;
      default:          arg_ok = 1'b0;
    endcase
  end

  // Data word k of a multi-register write
  always @* begin
    sel_word = 16'h0000;
    case ({kind, word_k[2:0]})
      {`MCC_KIND_SERIAL, 3'h0}: sel_word = `MCC_CMD_SERIAL;
      {`MCC_KIND_SERIAL, 3'h1}: sel_word = {12'h000, ser_baud};
      {`MCC_KIND_SERIAL, 3'h2}: sel_word = {14'h0000, ser_dbits};
      {`MCC_KIND_SERIAL, 3'h3}: sel_word = {15'h0000, ser_stop};
      {`MCC_KIND_SERIAL, 3'h4}: sel_word = {14'h0000, ser_par};
      {`MCC_KIND_CANSTD, 3'h0}: sel_word = `MCC_CMD_CANSTD;
      {`MCC_KIND_CANSTD, 3'h1}: sel_word = {12'h000, canstd};
      {`MCC_KIND_CANUSR, 3'h0}: sel_word = `MCC_CMD_CANUSR;
      {`MCC_KIND_CANUSR, 3'h1}: sel_word = canusr[31:16];
      {`MCC_KIND_CANUSR, 3'h2}: sel_word = canusr[15:0];
      default:                  sel_word = 16'h0000;
    endcase
  end

  // Frame body byte at tx_idx, CRC excluded
  always @* begin
    case (tx_idx)
      5'h00:   body_byte = node;
      5'h01:   body_byte = is_read ? `MCC_FC_RDINPUT : `MCC_FC_WRMULTI;
      5'h02:   body_byte = is_read ? msg_addr[15:8] : cfg_addr[15:8];
      5'h03:   body_byte = is_read ? msg_addr[7:0] : cfg_addr[7:0];
      5'h04:   body_byte = wcount[15:8];
      5'h05:   body_byte = wcount[7:0];
      5'h06:   body_byte = {wcount[6:0], 1'b0};
      default: body_byte = tx_idx[0] ? sel_word[15:8] : sel_word[7:0];
    endcase
  end

  // Avalon slave, one wait cycle per access
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      pop_ok          <= 1'b0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        pop_ok <= 1'b0;
        case (avs_address)
          `MCC_REG_CMD:    avs_readdata <= {27'h0, err, done, busy};
          `MCC_REG_NODE:   avs_readdata <= {24'h0, node};
          `MCC_REG_SERCFG: avs_readdata <= {22'h0, sercfg};
          `MCC_REG_CANSTD: avs_readdata <= {28'h0, canstd};
          `MCC_REG_CANUSR: avs_readdata <= canusr;
          `MCC_REG_RDCNT:  avs_readdata <= {27'h0, rdcnt};
          `MCC_REG_RXWORD: begin
            avs_readdata <= {15'h0, buf_valid, buf_data};
            pop_ok       <= buf_valid;
          end
          default:         avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Command engine
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state    <= ST_IDLE;
      kind     <= 3'h0;
      node     <= 8'h01;
      sercfg   <= 10'h000;
      canstd   <= 4'h0;
      canusr   <= 32'h0000_0000;
      rdcnt    <= 5'h01;
      busy     <= 1'b0;
      done     <= 1'b0;
      err      <= `MCC_ERR_NONE;
      tx_idx   <= 5'h00;
      tx_crc   <= `MCC_CRC_INIT;
      tx_data  <= 8'h00;
      tx_valid <= 1'b0;
      tx_last  <= 1'b0;
      rx_idx   <= 8'h00;
      rx_len   <= 8'h00;
      rx_crc   <= `MCC_CRC_INIT;
      rx_hi    <= 8'h00;
      rx_bad   <= 1'b0;
      rx_exc   <= 1'b0;
      timer    <= 32'h0000_0000;
    end else begin
      if (acc && avs_write && !busy) begin
        case (avs_address)
          `MCC_REG_NODE:   node   <= avs_writedata[7:0];
          `MCC_REG_SERCFG: sercfg <= avs_writedata[9:0];
          `MCC_REG_CANSTD: canstd <= avs_writedata[3:0];
          `MCC_REG_CANUSR: canusr <= avs_writedata;
          `MCC_REG_RDCNT:  rdcnt  <= avs_writedata[4:0];
          `MCC_REG_CMD: begin
            done <= 1'b0;
            if (arg_ok) begin
              kind   <= cmd_kind[2:0];
              busy   <= 1'b1;
              err    <= `MCC_ERR_NONE;
              tx_idx <= 5'h00;
              tx_crc <= `MCC_CRC_INIT;
              state  <= ST_SEND;
            end else begin
              err  <= `MCC_ERR_ARG;
              done <= 1'b1;
            end
          end
          default: ;
        endcase
      end
      case (state)
        ST_SEND: begin
          if (!tx_valid || tx_ready) begin
            if (tx_idx == body_len + 5'h02) begin
              tx_valid <= 1'b0;
              tx_last  <= 1'b0;
              rx_idx   <= 8'h00;
              rx_len   <= is_read ? 8'h05 : 8'h08;
              rx_crc   <= `MCC_CRC_INIT;
              rx_bad   <= 1'b0;
              rx_exc   <= 1'b0;
              timer    <= 32'h0000_0000;
              state    <= ST_WAIT;
            end else begin
              tx_valid <= 1'b1;
              tx_last  <= (tx_idx == body_len + 5'h01);
              if (tx_idx < body_len) begin
                tx_data <= body_byte;
                tx_crc  <= mcc_crc(tx_crc, body_byte);
              end else begin
                tx_data <= (tx_idx == body_len) ? tx_crc[7:0] : tx_crc[15:8];
              end
              tx_idx <= tx_idx + 5'h01;
            end
          end
        end
        ST_WAIT: begin
          timer <= timer + 32'h0000_0001;
          if (rx_take) begin
            rx_idx <= rx_idx + 8'h01;
            rx_crc <= rx_crc_nx;
            rx_hi  <= rx_data;
            case (rx_idx)
              8'h00: if (rx_data != node) rx_bad <= 1'b1;
              8'h01: begin
                if (rx_data[`MCC_FC_EXCEPT_BIT]) begin
                  rx_exc <= 1'b1;
                  rx_len <= 8'h05;
                end else if (rx_data != (is_read ? `MCC_FC_RDINPUT : `MCC_FC_WRMULTI)) begin
                  rx_bad <= 1'b1;
                end
              end
              8'h02: begin
                if (is_read && !rx_exc) begin
                  rx_len <= rd_bytes + 8'h05;
                  if (rx_data != rd_bytes) rx_bad <= 1'b1;
                end else if (!rx_exc && rx_data != `MCC_CFG_ADDR >> 8) begin
                  rx_bad <= 1'b1;
                end
              end
              8'h03: if (!is_read && !rx_exc && rx_data != (`MCC_CFG_ADDR & 8'hFF)) rx_bad <= 1'b1;
              8'h04: if (!is_read && rx_data != 8'h00) rx_bad <= 1'b1;
              8'h05: if (!is_read && rx_data != wcount[7:0]
                         && {8'h00, rx_data} != `MCC_WC_ECHO_ALT) rx_bad <= 1'b1;
              default: ;
            endcase
            if (rx_idx == rx_len - 8'h01 && !(rx_idx == 8'h01 && rx_data[`MCC_FC_EXCEPT_BIT])
                && !(rx_idx == 8'h02 && is_read && !rx_exc)) begin
              if (rx_exc) begin
                err   <= `MCC_ERR_EXCEPT;
                done  <= 1'b1;
                busy  <= 1'b0;
                state <= ST_IDLE;
              end else if (rx_bad || rx_crc_nx != 16'h0000) begin
                err   <= `MCC_ERR_FRAME;
                done  <= 1'b1;
                busy  <= 1'b0;
                state <= ST_IDLE;
              end else if (is_read) begin
                done  <= 1'b1;
                busy  <= 1'b0;
                state <= ST_IDLE;
              end else begin
                timer <= 32'h0000_0000;
                state <= ST_REBOOT;
              end
            end
          end else if (timer >= RESP_CYC - 1) begin
            err   <= `MCC_ERR_TIMEOUT;
            done  <= 1'b1;
            busy  <= 1'b0;
            state <= ST_IDLE;
          end
        end
        ST_REBOOT: begin
          // Device is rebooting; hold off any new command
          timer <= timer + 32'h0000_0001;
          if (timer >= REBOOT_CYC - 1) begin
            done  <= 1'b1;
            busy  <= 1'b0;
            state <= ST_IDLE;
          end
        end
        // Idle must not override a command start above
        ST_IDLE: ;
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: design/mcc_map.vh
// Constants for the Modbus RTU configuration master: register map, frame fields,
// command codes, error codes and timing figures.
// Assumes a 100 MHz system clock and a byte-wide serial framer outside.
`ifndef MCC_MAP_VH
`define MCC_MAP_VH

`define MCC_CLK_MHZ          100
`define MCC_RESP_TIMEOUT_MS  100
`define MCC_REBOOT_MS        2000

// Avalon word indices
`define MCC_REG_CMD          3'h0
`define MCC_REG_NODE         3'h1
`define MCC_REG_SERCFG       3'h2
`define MCC_REG_CANSTD       3'h3
`define MCC_REG_CANUSR       3'h4
`define MCC_REG_RDCNT        3'h5
`define MCC_REG_RXWORD       3'h6

// Command kinds written to CMD[2:0]
`define MCC_KIND_SERIAL      3'h1
`define MCC_KIND_CANSTD      3'h2
`define MCC_KIND_CANUSR      3'h3
`define MCC_KIND_READ        3'h4

// Modbus frame fields
`define MCC_FC_WRMULTI       8'h10
`define MCC_FC_RDINPUT       8'h04
`define MCC_FC_EXCEPT_BIT    7
`define MCC_CFG_ADDR         16'h0100
`define MCC_MSG_ADDR         16'h0000
`define MCC_CMD_SERIAL       16'h0003
`define MCC_CMD_CANSTD       16'h0004
`define MCC_CMD_CANUSR       16'h0005
`define MCC_WC_SERIAL        16'h0005
`define MCC_WC_CANSTD        16'h0002
`define MCC_WC_CANUSR        16'h0003
`define MCC_WC_ECHO_ALT      16'h0002
`define MCC_REGS_PER_MSG     16'h0009
`define MCC_MAX_MSGS         5'h0D
`define MCC_CRC_INIT         16'hFFFF
`define MCC_CRC_POLY         16'hA001

// Argument code limits
`define MCC_BAUD_MIN         4'h2
`define MCC_BAUD_MAX         4'hC
`define MCC_DBITS_MAX        2'h3
`define MCC_PARITY_MAX       2'h2
`define MCC_CAN_MAX          4'h8
`define MCC_CAN_USER         4'hF

// SERCFG field positions
`define MCC_SER_BAUD_LSB     0
`define MCC_SER_DBITS_LSB    4
`define MCC_SER_STOP_BIT     6
`define MCC_SER_PAR_LSB      8

// Error codes in STATUS[4:2]
`define MCC_ERR_NONE         3'h0
`define MCC_ERR_ARG          3'h1
`define MCC_ERR_EXCEPT       3'h2
`define MCC_ERR_FRAME        3'h3
`define MCC_ERR_TIMEOUT      3'h4

`endif

// File: design/mcc_buf2.v
// Two-entry word buffer with valid/ready on both sides.
// Assumes one clock; in_ready is registered.
`timescale 1ns/10ps
`default_nettype none
module mcc_buf2 #(
  parameter WIDTH = 16
) (
  input  wire             clk_sys,
  input  wire             arst_n,
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output reg              in_ready,
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready
);
  reg [WIDTH-1:0] slot0;
  reg [WIDTH-1:0] slot1;
  reg [1:0]       count;
  reg [1:0]       next_count;
  wire            push;
  wire            pop;

  assign out_valid = (count != 2'h0);
  assign out_data  = slot0;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always @* begin
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      slot0    <= {WIDTH{1'b0}};
      slot1    <= {WIDTH{1'b0}};
      count    <= 2'h0;
      in_ready <= 1'b0;
    end else begin
      count    <= next_count;
      in_ready <= (next_count != 2'h2);
      if (pop) begin
        slot0 <= (push && count == 2'h1) ? in_data : slot1;
        if (push && count == 2'h2) begin
          slot1 <= in_data;
        end
      end else if (push) begin
        if (count == 2'h0) begin
          slot0 <= in_data;
        end else begin
          slot1 <= in_data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/mcc_host_asserts.sv
// Checker for the configuration master's Avalon and byte-stream ports.
// Assumes it is bound to mcc_host and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module mcc_host_asserts (
  input wire logic       clk_sys,
  input wire logic       arst_n,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [7:0] tx_data,
  input wire logic       tx_valid,
  input wire logic       tx_last,
  input wire logic       tx_ready,
  input wire logic       rx_valid,
  input wire logic       rx_ready
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  logic [7:0] bi;
  logic [7:0] fc;
  logic [7:0] wc;
  wire        hs = tx_valid && tx_ready;
  // Byte index in frame, function code and word count
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      bi <= 8'h00;
      fc <= 8'h00;
      wc <= 8'h00;
    end else if (hs) begin
      bi <= tx_last ? 8'h00 : bi + 8'h01;
      if (bi == 8'h01) fc <= tx_data;
      if (bi == 8'h05) wc <= tx_data;
    end
  end
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  tx_held_a: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("byte changed before taken");
  frame_len_a: assert property (tx_last |-> tx_valid && bi >= 8'h07)
    else $error("frame too short");
  func_code_a: assert property (hs && bi == 8'h01 |-> tx_data inside {8'h10, 8'h04})
    else $error("bad function code");
  cfg_addr_a: assert property (hs && fc == 8'h10 && (bi == 8'h02 || bi == 8'h03) |->
    tx_data == ((bi == 8'h02) ? 8'h01 : 8'h00))
    else $error("config start address wrong");
  msg_addr_a: assert property (hs && fc == 8'h04 && bi inside {[8'h02:8'h04]} |->
    tx_data == 8'h00)
    else $error("message read address wrong");
  wc_kind_a: assert property (hs && fc == 8'h10 && bi == 8'h05 |->
    tx_data inside {8'h05, 8'h02, 8'h03})
    else $error("bad config word count");
  wc_nine_a: assert property (hs && fc == 8'h04 && bi == 8'h05 |->
    tx_data != 8'h00 && tx_data % 8'h09 == 8'h00)
    else $error("read count not a multiple of nine");
  byte_cnt_a: assert property (hs && fc == 8'h10 && bi == 8'h06 |->
    tx_data == {wc[6:0], 1'b0})
    else $error("byte count not twice word count");
  cmd_word_a: assert property (hs && fc == 8'h10 && bi == 8'h08 |->
    tx_data == ((wc == 8'h05) ? 8'h03 : (wc == 8'h02) ? 8'h04 : 8'h05))
    else $error("command word does not match count");
  cover property (hs && tx_last && fc == 8'h10);
  cover property (hs && tx_last && fc == 8'h04);
  cover property (rx_valid && !rx_ready);
endmodule
`default_nettype wire

// File: bench/mcc_dev_model.sv
// Behavioural converter slave: takes request bytes, answers echo,
// exception or message reads. Assumes the byte stream ports of mcc_host.
`timescale 1ns/10ps
`default_nettype none
module mcc_dev_model #(
  parameter logic [7:0] NODE_ID = 8'h01
) (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       stall,
  input  wire logic [1:0] mode,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  input  wire logic       rx_ready
);
  logic [7:0]  fr [0:255];
  logic [7:0]  rb [0:255];
  int          fn = 0, rn = 0, rp = 0, gap = 0, fcnt = 0, head = 0, wn = 0;
  logic        crc_ok = 1'b0;
  logic        use_user = 1'b0;
  logic [31:0] user_bps = 32'h0;
  logic [15:0] c;
  logic [15:0] w;
  function automatic logic [15:0] crc(input logic [7:0] a [0:255], input int n);
    logic [15:0] r;
    r = 16'hFFFF;
    for (int i = 0; i < n; i++) begin
      r = r ^ {8'h00, a[i]};
      for (int j = 0; j < 8; j++) r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
    end
    return r;
  endfunction
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      tx_ready <= 1'b0;
      rx_valid <= 1'b0;
      rx_data  <= 8'h00;
      fn = 0;
      rn = 0;
    end else begin
      tx_ready <= stall ? ~tx_ready : 1'b1;
      if (rx_valid && rx_ready) begin
        rp = rp + 1;
        gap = stall ? 3 : 0;
      end
      if (tx_valid && tx_ready) begin
        fr[fn] = tx_data;
        fn = fn + 1;
        if (tx_last) begin
          c = crc(fr, fn - 2);
          crc_ok = (c === {fr[fn-1], fr[fn-2]});
          fcnt = fcnt + 1;
          wn = {fr[4], fr[5]};
          rn = 6;
          for (int i = 0; i < 6; i++) rb[i] = fr[i];
          if (fr[1] == 8'h04) begin
            rb[2] = 8'(2 * wn);
            for (int k = 0; k < wn; k++) begin
              w = 16'hC000 | 16'((head + k / 9) << 8) | 16'(k % 9);
              rb[3+2*k] = w[15:8];
              rb[4+2*k] = w[7:0];
            end
            head = head + wn / 9;
            rn = 3 + 2 * wn;
          end else if ({fr[7], fr[8]} == 16'h0005) begin
            user_bps = {fr[9], fr[10], fr[11], fr[12]};
          end else if ({fr[7], fr[8]} == 16'h0004) begin
            use_user = ({fr[9], fr[10]} == 16'h000F);
          end
          if (mode == 2'h1) begin
            rb[1] = fr[1] | 8'h80;
            rb[2] = 8'h02;
            rn = 3;
          end
          // Mode 3 corrupts the echoed address under a good CRC
          if (mode == 2'h3) rb[3] = ~rb[3];
          // A real slave stays silent on bad CRC or foreign node
          if (mode == 2'h2 || !crc_ok || fr[0] != NODE_ID) rn = 0;
          c = crc(rb, rn);
          rb[rn] = c[7:0];
          rb[rn+1] = c[15:8];
          if (rn > 0) rn = rn + 2;
          rp = 0;
          gap = 4;
          fn = 0;
        end
      end
      if (gap > 0) gap = gap - 1;
      if (!rx_valid || rx_ready) begin
        if (rp < rn && gap == 0) begin
          rx_valid <= 1'b1;
          rx_data  <= rb[rp];
        end else begin
          rx_valid <= 1'b0;
          rx_data  <= ~rx_data;
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
// Testbench for mcc_host: Avalon tasks, slave model, checker bind.
// Assumes mcc_map.vh on the include path and shortened timing parameters.
`timescale 1ns/10ps
`default_nettype none
`include "mcc_map.vh"
module tb_top;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic [2:0]  avs_address = 3'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        stall = 1'b0;
  logic [1:0]  mode = 2'h0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire  [7:0]  tx_data;
  wire         tx_valid, tx_last, tx_ready;
  wire  [7:0]  rx_data;
  wire         rx_valid, rx_ready;
  int          num_errors = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          mexp = 0;
  int          n0;
  logic [31:0] q;
  logic [3:0]  code;
  always #5 clk_sys = ~clk_sys;
  mcc_host #(.RESP_CYC(2000), .REBOOT_CYC(100)) i_mcc_host (
    .clk_sys, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .tx_data, .tx_valid, .tx_last, .tx_ready,
    .rx_data, .rx_valid, .rx_ready);
  mcc_dev_model i_mcc_dev_model (
    .clk_sys, .arst_n, .stall, .mode, .tx_data, .tx_valid, .tx_last, .tx_ready,
    .rx_data, .rx_valid, .rx_ready);
  task automatic summarize();
    if (num_errors == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic w, input logic [2:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) chk(n, 0);
  endtask
  task automatic fin(input logic [2:0] e);
    int n;
    n = 0;
    do begin
      av(1'b0, `MCC_REG_CMD, 32'h0);
      n++;
    end while (q[0] !== 1'b0 && n < 4000);
    chk(q[4:0], {e, 2'b10});
  endtask
  task automatic cmd(input logic [2:0] k, input logic [2:0] e);
    av(1'b1, `MCC_REG_CMD, {29'h0, k});
    fin(e);
  endtask
  function automatic logic [15:0] fw(input int k);
    return {i_mcc_dev_model.fr[7+2*k], i_mcc_dev_model.fr[8+2*k]};
  endfunction
  task automatic hdr(input logic [7:0] f, input logic [15:0] a, input logic [15:0] w);
    chk(i_mcc_dev_model.fr[1], f);
    chk({i_mcc_dev_model.fr[2], i_mcc_dev_model.fr[3]}, a);
    chk({i_mcc_dev_model.fr[4], i_mcc_dev_model.fr[5]}, w);
    chk(i_mcc_dev_model.crc_ok, 1'b1);
    if (f == 8'h10) chk(i_mcc_dev_model.fr[6], {w[6:0], 1'b0});
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      summarize();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    av(1'b0, `MCC_REG_NODE, 32'h0);
    chk(q, 32'h1);
    av(1'b0, `MCC_REG_RDCNT, 32'h0);
    chk(q, 32'h1);
    av(1'b1, 3'h7, 32'h5);
    av(1'b0, 3'h7, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++) begin
      code = (i == 0) ? 4'h2 : (i == 1) ? 4'hC : 4'h7 + 4'(i);
      av(1'b1, `MCC_REG_SERCFG, {22'h0, 2'(i % 3), 1'b0, i[0], 2'(i), code});
      av(1'b1, `MCC_REG_CMD, {29'h0, `MCC_KIND_SERIAL});
      // Written while busy, must be dropped
      av(1'b1, `MCC_REG_NODE, 32'h55);
      fin(3'h0);
      hdr(8'h10, 16'h0100, 16'h0005);
      chk(fw(0), 32'h3);
      chk(fw(1), code);
      chk(fw(2), i);
      chk(fw(3), i % 2);
      chk(fw(4), i % 3);
    end
    av(1'b0, `MCC_REG_NODE, 32'h0);
    chk(q, 32'h1);
    for (int i = 0; i < 4; i++) begin
      n0 = i_mcc_dev_model.fcnt;
      av(1'b1, (i == 3) ? `MCC_REG_CANSTD : `MCC_REG_SERCFG,
         (i == 0) ? 32'h1 : (i == 1) ? 32'hD : (i == 2) ? 32'h302 : 32'h9);
      cmd((i == 3) ? `MCC_KIND_CANSTD : `MCC_KIND_SERIAL, 3'h1);
      chk(i_mcc_dev_model.fcnt, n0);
    end
    av(1'b1, `MCC_REG_CANUSR, 32'h14585);
    cmd(`MCC_KIND_CANUSR, 3'h0);
    hdr(8'h10, 16'h0100, 16'h0003);
    chk(fw(0), 32'h5);
    chk({fw(1), fw(2)}, 32'h14585);
    for (int i = 0; i < 10; i++) begin
      code = (i == 9) ? 4'hF : 4'(i);
      av(1'b1, `MCC_REG_CANSTD, {28'h0, code});
      cmd(`MCC_KIND_CANSTD, 3'h0);
      hdr(8'h10, 16'h0100, 16'h0002);
      chk(fw(0), 32'h4);
      chk(fw(1), code);
    end
    chk(i_mcc_dev_model.use_user, 1'b1);
    mode <= 2'h1;
    cmd(`MCC_KIND_CANSTD, 3'h2);
    mode <= 2'h2;
    cmd(`MCC_KIND_CANSTD, 3'h4);
    mode <= 2'h3;
    cmd(`MCC_KIND_CANSTD, 3'h3);
    mode <= 2'h0;
    stall <= 1'b1;
    for (int r = 2; r > 0; r--) begin
      av(1'b1, `MCC_REG_RDCNT, r);
      av(1'b1, `MCC_REG_CMD, {29'h0, `MCC_KIND_READ});
      // Let the word buffer fill and back-pressure the slave
      repeat (150) @(posedge clk_sys);
      for (int k = 0; k < 9 * r; k++) begin
        n0 = 0;
        do begin
          av(1'b0, `MCC_REG_RXWORD, 32'h0);
          n0++;
        end while (q[16] !== 1'b1 && n0 < 100);
        chk(q[16:0], {1'b1, 16'hC000 | 16'((mexp + k / 9) << 8) | 16'(k % 9)});
      end
      mexp = mexp + r;
      fin(3'h0);
      hdr(8'h04, 16'h0000, 16'(9 * r));
      av(1'b0, `MCC_REG_RXWORD, 32'h0);
      chk(q[16], 1'b0);
    end
    summarize();
  end
endmodule
bind mcc_host mcc_host_asserts i_mcc_host_asserts (
  .clk_sys, .arst_n, .avs_read, .avs_write, .avs_waitrequest, .tx_data,
  .tx_valid, .tx_last, .tx_ready, .rx_valid, .rx_ready);
`default_nettype wire
